// ### design/aao_regs.svh
// register offsets, field positions, reset values and encodings of the add/and datapath
`ifndef AAO_REGS_SVH
`define AAO_REGS_SVH

// ----------------------------------------------------------------------------
// register byte offsets (word index = offset / 4)
// ----------------------------------------------------------------------------
`define AAO_OFS_INSTR 10'h000
`define AAO_OFS_WREG 10'h004
`define AAO_OFS_STATUS 10'h008
`define AAO_OFS_RESULT 10'h00C
`define AAO_OFS_COUNT 10'h010
`define AAO_OFS_FILE_BASE 10'h100
`define AAO_ADR_W 10

// ----------------------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------------------
`define AAO_IW_OP_LSB 0
`define AAO_IW_OP_MSB 1
`define AAO_IW_DEST_BIT 2
`define AAO_IW_FADR_LSB 8
`define AAO_IW_FADR_MSB 13
`define AAO_IW_LIT_LSB 16
`define AAO_IW_LIT_MSB 23

// ----------------------------------------------------------------------------
// opcode encodings
// ----------------------------------------------------------------------------
`define AAO_OP_ADD_REG 2'h0
`define AAO_OP_ADD_LIT 2'h1
`define AAO_OP_AND_REG 2'h2
`define AAO_OP_AND_LIT 2'h3

// ----------------------------------------------------------------------------
// status bits
// ----------------------------------------------------------------------------
`define AAO_ST_C 0
`define AAO_ST_DC 1
`define AAO_ST_Z 2
`define AAO_ST_LAST_FILE 4
`define AAO_ST_LAST_ADD 5

// ----------------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------------
`define AAO_RST_BYTE 8'h00
`define AAO_RST_INSTR 24'h000000
`define AAO_RST_COUNT 16'h0000
`define AAO_FILE_DEPTH 64
`define AAO_DEST_WREG 1'b0
`define AAO_DEST_FILE 1'b1
`define AAO_SEL_ALL 4'hF

`endif

// ### design/aao_pkg.sv
// types shared by the add/and datapath modules
`include "aao_regs.svh"

package aao_pkg;

    typedef enum logic [1:0] {
        AAO_ADD_REG = `AAO_OP_ADD_REG,
        AAO_ADD_LIT = `AAO_OP_ADD_LIT,
        AAO_AND_REG = `AAO_OP_AND_REG,
        AAO_AND_LIT = `AAO_OP_AND_LIT
    } aao_op_t;

    typedef struct packed {
        logic z;
        logic half_carry_flag;
        logic c;
    } aao_flags_t;

endpackage

// ### design/aao_alu_if.sv
// operand and result bundle between the core and its arithmetic unit
`timescale 1ns/100ps

interface aao_alu_if;
    logic [7:0] opa;
    logic [7:0] opb;
    logic do_add;
    logic [7:0] result;
    logic carry;
    logic half_carry;
    logic zero;

    modport core (output opa, output opb, output do_add, input result, input carry, input half_carry, input zero);
    modport alu (input opa, input opb, input do_add, output result, output carry, output half_carry, output zero);
endinterface

// ### design/aao_alu.sv
// 8-bit add / and unit with carry, half-carry and zero outputs
`timescale 1ns/100ps

module aao_alu (
    aao_alu_if.alu bus
);
    wire [4:0] low_sum;
    wire [8:0] full_sum;
    wire [7:0] and_res;

    // ------------------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------------------
    assign low_sum = {1'b0, bus.opa[3:0]} + {1'b0, bus.opb[3:0]};
    assign full_sum = {1'b0, bus.opa} + {1'b0, bus.opb};
    assign and_res = bus.opa & bus.opb;

    assign bus.result = bus.do_add ? full_sum[7:0] : and_res;
    assign bus.carry = full_sum[8];
    assign bus.half_carry = low_sum[4];
    assign bus.zero = (bus.result == 8'h00);
endmodule // aao_alu

// ### design/aao_core.sv
// add/and execution datapath with working register, file registers and wishbone slave
`timescale 1ns/100ps
`include "aao_regs.svh"

// Summary of operation
// - register add sums working register and file
// - dest bit 0 to working, 1 to file
// - literal add always lands in working register
// - both adds update carry, half-carry, zero
// - register and writes to chosen destination
// - register and touches zero flag only
// - literal and writes working register
// - every instruction finishes in one cycle
// - file address is six bits, 0..63
// - literal is eight bits, 0..255
module aao_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`AAO_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [7:0] working_register_o,
    output logic carry_o,
    output logic half_carry_flag_o,
    output logic zero_o
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [7:0] file_mem [0:`AAO_FILE_DEPTH-1];
    logic [7:0] working_register_r;
    aao_pkg::aao_flags_t flags_r;
    logic last_file_r;
    logic last_add_r;
    logic [23:0] instr_r;
    logic [7:0] result_r;
    logic [15:0] count_r;
    logic ack_r;
    logic [31:0] rdat_r;

    aao_alu_if alu_bus ();

    aao_alu u_alu (
        .bus (alu_bus)
    );

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    wire req = wb_cyc_i & wb_stb_i;
    // writes land only on the ack edge, so the master's held request is used once
    wire wr_go = req & wb_we_i & ack_r;
    wire hit_instr = (wb_adr_i == `AAO_OFS_INSTR);
    wire hit_wreg = (wb_adr_i == `AAO_OFS_WREG);
    wire hit_status = (wb_adr_i == `AAO_OFS_STATUS);
    wire hit_result = (wb_adr_i == `AAO_OFS_RESULT);
    wire hit_count = (wb_adr_i == `AAO_OFS_COUNT);
    wire hit_file = (wb_adr_i[`AAO_ADR_W-1:8] == 2'(`AAO_OFS_FILE_BASE >> 8));
    wire [5:0] bus_fadr = wb_adr_i[7:2];

    // partial writes to the instruction word are dropped: a torn opcode would execute
    wire exec_go = wr_go & hit_instr & (wb_sel_i == `AAO_SEL_ALL);
    wire wreg_wr = wr_go & hit_wreg & wb_sel_i[0];
    wire status_wr = wr_go & hit_status & wb_sel_i[0];
    wire file_wr = wr_go & hit_file & wb_sel_i[0];

    // ------------------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------------------
    wire [1:0] op_raw = wb_dat_i[`AAO_IW_OP_MSB:`AAO_IW_OP_LSB];
    wire aao_pkg::aao_op_t op = aao_pkg::aao_op_t'(op_raw);
    wire dest_bit = wb_dat_i[`AAO_IW_DEST_BIT];
    wire [5:0] fadr = wb_dat_i[`AAO_IW_FADR_MSB:`AAO_IW_FADR_LSB];
    wire [7:0] literal = wb_dat_i[`AAO_IW_LIT_MSB:`AAO_IW_LIT_LSB];

    wire add_reg_op = (op == aao_pkg::AAO_ADD_REG);
    wire add_literal_op = (op == aao_pkg::AAO_ADD_LIT);
    wire and_reg_op = (op == aao_pkg::AAO_AND_REG);
    wire and_literal_op = (op == aao_pkg::AAO_AND_LIT);
    wire is_add = add_reg_op | add_literal_op;
    wire is_lit = add_literal_op | and_literal_op;

    // ------------------------------------------------------------------------
    // operand routing
    // ------------------------------------------------------------------------
    wire [7:0] file_operand = file_mem[fadr];
    assign alu_bus.opa = working_register_r;
    assign alu_bus.opb = is_lit ? literal : file_operand;
    assign alu_bus.do_add = is_add;

    // literal forms ignore the destination bit
    wire to_file = ~is_lit & (dest_bit == `AAO_DEST_FILE);
    wire to_wreg = ~to_file;

    wire exec_wreg = exec_go & to_wreg;
    wire exec_file = exec_go & to_file;

    // ------------------------------------------------------------------------
    // next values
    // ------------------------------------------------------------------------
    wire [7:0] working_register_nxt = exec_wreg ? alu_bus.result :
                                      wreg_wr ? wb_dat_i[7:0] : working_register_r;

    // and forms keep carry and half-carry as they were
    wire c_nxt = exec_go ? (is_add ? alu_bus.carry : flags_r.c) :
                 status_wr ? wb_dat_i[`AAO_ST_C] : flags_r.c;
    wire dc_nxt = exec_go ? (is_add ? alu_bus.half_carry : flags_r.half_carry_flag) :
                  status_wr ? wb_dat_i[`AAO_ST_DC] : flags_r.half_carry_flag;
    wire z_nxt = exec_go ? alu_bus.zero :
                 status_wr ? wb_dat_i[`AAO_ST_Z] : flags_r.z;

    wire [15:0] count_nxt = count_r + 16'h0001;

    // ------------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------------
    wire [7:0] status_byte = {2'b00, last_add_r, last_file_r, 1'b0,
                              flags_r.z, flags_r.half_carry_flag, flags_r.c};
    wire [31:0] rd_instr = {8'h00, instr_r};
    wire [31:0] rd_wreg = {24'h000000, working_register_r};
    wire [31:0] rd_status = {24'h000000, status_byte};
    wire [31:0] rd_result = {24'h000000, result_r};
    wire [31:0] rd_count = {16'h0000, count_r};
    wire [31:0] rd_file = {24'h000000, file_mem[bus_fadr]};
    // unmapped addresses still ack and read zero
    wire [31:0] rd_mux = hit_instr ? rd_instr :
                         hit_wreg ? rd_wreg :
                         hit_status ? rd_status :
                         hit_result ? rd_result :
                         hit_count ? rd_count :
                         hit_file ? rd_file : 32'h00000000;

    // ------------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_r <= 32'h00000000;
        end else if (req & ~ack_r) begin
            rdat_r <= rd_mux;
        end
    end

    // ------------------------------------------------------------------------
    // working register and flags
    // ------------------------------------------------------------------------
    // the whole instruction commits on one edge, so the next can follow at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            working_register_r <= `AAO_RST_BYTE;
            flags_r <= '0;
        end else begin
            working_register_r <= working_register_nxt;
            flags_r.c <= c_nxt;
            flags_r.half_carry_flag <= dc_nxt;
            flags_r.z <= z_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // trace of the last instruction
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_r <= `AAO_RST_INSTR;
            result_r <= `AAO_RST_BYTE;
            last_file_r <= 1'b0;
            last_add_r <= 1'b0;
            count_r <= `AAO_RST_COUNT;
        end else if (exec_go) begin
            instr_r <= wb_dat_i[23:0];
            result_r <= alu_bus.result;
            last_file_r <= to_file;
            last_add_r <= is_add;
            count_r <= count_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // file registers
    // ------------------------------------------------------------------------
    // no reset: the array models plain data memory, contents undefined at power-up
    always_ff @(posedge clk_i) begin
        if (exec_file) begin
            file_mem[fadr] <= alu_bus.result;
        end else if (file_wr) begin
            file_mem[bus_fadr] <= wb_dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign working_register_o = working_register_r;
    assign carry_o = flags_r.c;
    assign half_carry_flag_o = flags_r.half_carry_flag;
    assign zero_o = flags_r.z;

endmodule // aao_core

// ### verif/aao_core_checker.sv
// assertion checker for the add/and datapath ports
`timescale 1ns/100ps
`include "aao_regs.svh"
module aao_core_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`AAO_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] working_register_o,
    input wire logic carry_o,
    input wire logic half_carry_flag_o,
    input wire logic zero_o
);
    // ------------------------------------------------------------------
    // helper terms
    // ------------------------------------------------------------------
    wire logic ins_ack = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `AAO_OFS_INSTR
        && wb_sel_i == `AAO_SEL_ALL;
    logic [8:0] sum_h;
    logic [4:0] nib_h;
    logic [7:0] and_h;
    // expected values captured at the commit edge, compared one cycle on
    always_ff @(posedge clk_i) begin
        sum_h <= working_register_o + wb_dat_i[23:16];
        nib_h <= working_register_o[3:0] + wb_dat_i[19:16];
        and_h <= working_register_o & wb_dat_i[23:16];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence lit_add_s; ins_ack && wb_dat_i[1:0] == 2'h1; endsequence
    sequence lit_and_s; ins_ack && wb_dat_i[1:0] == 2'h3; endsequence
    sequence file_dest_s; ins_ack && !wb_dat_i[0] && wb_dat_i[2]; endsequence
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_lit_add_sum: assert property (lit_add_s |=> working_register_o == sum_h[7:0] && carry_o == sum_h[8])
        else $error("literal add sum or carry wrong");
    chk_lit_add_half: assert property (lit_add_s |=> half_carry_flag_o == nib_h[4])
        else $error("half carry wrong");
    chk_lit_and_val: assert property (lit_and_s |=> working_register_o == and_h)
        else $error("literal and wrong");
    chk_and_keeps_carry: assert property (ins_ack && wb_dat_i[1] |=> $stable(carry_o) && $stable(half_carry_flag_o))
        else $error("and changed carries");
    chk_lit_zero: assert property (ins_ack && wb_dat_i[0] |=> zero_o == (working_register_o == 8'h00))
        else $error("zero flag wrong");
    chk_file_dest_hold: assert property (file_dest_s |=> $stable(working_register_o))
        else $error("working register hit on file dest");
endmodule // aao_core_checker

bind aao_core aao_core_checker aao_core_checker_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .working_register_o, .carry_o, .half_carry_flag_o, .zero_o);

// ### verif/aao_bus_model.sv
// wishbone master standing in for the decoder side
`timescale 1ns/100ps
module aao_bus_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] rdat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [9:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 10'h000;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    // ------------------------------------------------------------------
    // single classic cycle
    // ------------------------------------------------------------------
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= d;
        // no cycle limit here: only the bench timeout ends a stuck wait
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        q = rdat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // released lines flip so stale values cannot pass for live ones
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
endmodule // aao_bus_model

// ### verif/tb_add_and_alu_ops.sv
// self-checking bench for the add/and datapath
`timescale 1ns/100ps
`include "aao_regs.svh"
module tb_add_and_alu_ops;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, cr, hc, zr;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [7:0] wreg;
    int bad_count = 0, comparisons = 0, cyc_n = 0, seed = 87;
    int acc = 0, cf = 0, hf = 0, zf = 0, lr = 0;
    int fm [64];
    always #20 clk_i = ~clk_i;
    aao_core aao_core_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .working_register_o(wreg),
        .carry_o(cr), .half_carry_flag_o(hc), .zero_o(zr));
    aao_bus_model aao_bus_model_inst (.clk_i, .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    // ------------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n > 5000) begin
            bad_count++;
            end_sim;
        end
    end
    // reference model runs first, then the design sees the same word
    task automatic ex(input int op, input int d, input int f, input int l);
        int r;
        int b;
        b = op[0] ? l : fm[f];
        r = op[1] ? (acc & b) : (acc + b);
        if (!op[1]) begin
            cf = r >> 8;
            hf = ((acc & 15) + (b & 15)) >> 4;
        end
        r = r & 255;
        lr = r;
        zf = (r == 0);
        if (!op[0] && d) fm[f] = r;
        else acc = r;
        aao_bus_model_inst.xfer(1'b1, `AAO_OFS_INSTR, {8'(l), 2'b00, 6'(f), 5'b0, 1'(d), 2'(op)}, q);
        @(negedge clk_i);
        chk(wreg, acc);
        chk({zr, hc, cr}, {zf[0], hf[0], cf[0]});
        if (!op[0]) begin
            aao_bus_model_inst.xfer(1'b0, `AAO_OFS_FILE_BASE + 10'(4 * f), 32'h0, q);
            chk(q, fm[f]);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk({wreg, zr, hc, cr}, 32'h0);
        for (int n = 0; n < 64; n++) begin
            fm[n] = $random(seed) & 255;
            aao_bus_model_inst.xfer(1'b1, `AAO_OFS_FILE_BASE + 10'(4 * n), fm[n], q);
        end
        aao_bus_model_inst.xfer(1'b1, `AAO_OFS_WREG, 32'h1, q);
        acc = 1;
        ex(1, 0, 0, 255);
        ex(2, 1, 63, 0);
        for (int i = 0; i < 60; i++) ex($random(seed) & 3, $random(seed) & 1, $random(seed) & 63, $random(seed) & 255);
        aao_bus_model_inst.xfer(1'b0, `AAO_OFS_COUNT, 32'h0, q);
        chk(q, 62);
        aao_bus_model_inst.xfer(1'b0, `AAO_OFS_RESULT, 32'h0, q);
        chk(q, lr);
        aao_bus_model_inst.xfer(1'b0, 10'h3FC, 32'h0, q);
        chk(q, 32'h0);
        end_sim;
    end
endmodule // tb_add_and_alu_ops
